// [page_select_pkg.sv]
// Package with register map, field layout, reset values and access classes for page selection
package page_select_pkg;

   // Register offsets (byte addresses on the register bus)
   localparam logic [7:0] CUR_PAGE_OFFS = 8'hd0;
   localparam logic [7:0] STK_PAGE_OFFS = 8'hd1;
   localparam logic [7:0] IDX_PAGE_OFFS = 8'hd3;
   localparam logic [7:0] MOVE_RD_OFFS = 8'hd4;
   localparam logic [7:0] MOVE_WR_OFFS = 8'hd5;
   localparam logic [7:0] SCRATCH_OFFS = 8'h60;
   localparam logic [7:0] FLAGS_OFFS = 8'hd8;
   localparam logic [7:0] STATUS_OFFS = 8'hd9;

   // Field layout
   localparam int PAGE_W = 3;
   localparam int PAGE_LSB = 0;
   localparam int MODE_LSB = 6;
   localparam int MODE_W = 2;
   localparam int INPAGE_W = 8;
   localparam int SCRATCH_N = 4;

   // Reset values
   localparam logic [7:0] PP_RESET = 8'h00;
   localparam logic [7:0] SCRATCH_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // Page mode encodings
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_SVC_STACK = 2'h1;
   localparam logic [1:0] MODE_INDEX = 2'h2;
   localparam logic [1:0] MODE_STACK_IDX = 2'h3;

   // Access classes presented by the execution unit
   typedef enum logic [2:0] {
      ACC_NORMAL = 3'h0,
      ACC_INDEXED = 3'h1,
      ACC_STACK = 3'h2,
      ACC_MOVE_READ = 3'h3,
      ACC_MOVE_WRITE = 3'h4,
      ACC_REG_INDEXED = 3'h5
   } access_class_t;

endpackage : page_select_pkg

// [sram_page_select.sv]
// Page selection logic with Wishbone register slave
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/100ps
// What this block does
// - Mode 00b: normal and indexed use page 0
// - Mode 01b: indexed uses stack page pointer
// - Mode 10b: indexed uses index page pointer
// - Mode 11b: indexed uses stack page pointer
// - Current pointer applies only in modes 10b/11b
// - Current pointer never steers indexed or stack
// - Move pointer byte in current page, data elsewhere
// - Move read data page from move-read pointer
// - Move write data page from move-write pointer
// - Move pointers apply in every page mode
// - Stack uses stack pointer page, immediately effective
// - Reset clears the stack page pointer
// - Reset clears the page mode field
// - Interrupt entry clears flags; return restores them
// - Page pointers hold a full byte; the low three bits give the page number
// - Four scratch registers, bank and page independent
// - Register-space indexed accesses ignore paging
// - Stack pointer wraps within one page
module sram_page_select #(
   // Width of a page number
   parameter int PAGE_W = page_select_pkg::PAGE_W
) (
   // Clock and synchronous reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [7:0] dat_i,
   input wire logic sel_i,
   output logic [7:0] dat_o,
   output logic ack_o,
   // Access request from the execution unit
   input wire logic acc_valid_i,
   input wire logic [2:0] acc_class_i,
   input wire logic move_data_phase_i,
   input wire logic [7:0] acc_addr_i,
   // Stack pointer step from the execution unit
   input wire logic stack_push_i,
   input wire logic stack_pop_i,
   // Interrupt entry and return events
   input wire logic irq_entry_i,
   input wire logic irq_return_i,
   input wire logic [7:0] irq_return_flags_i,
   // Results
   output logic [PAGE_W+7:0] sram_addr_o,
   output logic sram_en_o,
   output logic [PAGE_W-1:0] sram_page_o,
   output logic [7:0] pushed_flags_o,
   output logic [7:0] stack_ptr_o
);

   // Software registers
   logic [7:0] cur_page_q; // Page for normal accesses
   logic [7:0] stk_page_q; // Page for the stack
   logic [7:0] idx_page_q; // Page for indexed accesses in mode 10b
   logic [7:0] move_rd_page_q; // Data page of a move into the accumulator
   logic [7:0] move_wr_page_q; // Data page of a move out of the accumulator
   logic [7:0] flags_q; // Flags, page mode in the top bits
   logic [7:0] scratch_q [page_select_pkg::SCRATCH_N]; // Free scratch bytes

   // Stack pointer
   logic [7:0] stack_ptr_q; // In-page stack offset

   // Bus acknowledge and read data
   logic ack_q; // One-cycle acknowledge
   logic [7:0] rdat_q; // Registered read data

   // Decode helpers
   logic wr_take; // Bus write accepted this cycle
   logic rd_take; // Bus read accepted this cycle
   logic [1:0] mode; // Page mode field
   logic [PAGE_W-1:0] page_d; // Page chosen for this access
   logic [PAGE_W-1:0] page_q; // Page of the last access
   logic [7:0] addr_q; // In-page byte of the last access
   logic en_q; // SRAM enable of the last access
   logic [7:0] status_rd; // Status byte for reads

   // A write or read is taken in the cycle before ack rises
   assign wr_take = cyc_i && stb_i && we_i && sel_i && !ack_q;
   assign rd_take = cyc_i && stb_i && !we_i && !ack_q;

   // Page mode field lives in the top flag bits
   assign mode = flags_q[page_select_pkg::MODE_LSB +: page_select_pkg::MODE_W];

   // Ack one cycle after the strobe, dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         // Blocking on ack_q keeps a held strobe from acking two cycles in a row
         ack_q <= cyc_i && stb_i && !ack_q;
      end
   end

   // Page pointer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_page_q <= page_select_pkg::PP_RESET;
         stk_page_q <= page_select_pkg::PP_RESET;
         idx_page_q <= page_select_pkg::PP_RESET;
         move_rd_page_q <= page_select_pkg::PP_RESET;
         move_wr_page_q <= page_select_pkg::PP_RESET;
      end else if (wr_take) begin
         // Full byte is stored; only low bits steer paging
         case (adr_i)
            page_select_pkg::CUR_PAGE_OFFS: cur_page_q <= dat_i;
            page_select_pkg::STK_PAGE_OFFS: stk_page_q <= dat_i;
            page_select_pkg::IDX_PAGE_OFFS: idx_page_q <= dat_i;
            page_select_pkg::MOVE_RD_OFFS: move_rd_page_q <= dat_i;
            page_select_pkg::MOVE_WR_OFFS: move_wr_page_q <= dat_i;
            default: begin
               // Other addresses leave the pointers alone
            end
         endcase
      end
   end

   // Scratch registers, reachable at any bank, no paging involved
   for (genvar g = 0; g < page_select_pkg::SCRATCH_N; g++) begin : g_scratch
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            scratch_q[g] <= page_select_pkg::SCRATCH_RESET;
         end else if (wr_take && adr_i == (page_select_pkg::SCRATCH_OFFS | 8'(g))) begin
            scratch_q[g] <= dat_i;
         end
      end
   end

   // Flags register: interrupt entry clears, return restores
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_q <= page_select_pkg::FLAGS_RESET;
      end else if (irq_entry_i) begin
         flags_q <= page_select_pkg::FLAGS_RESET;
      end else if (irq_return_i) begin
         // Return brings back the pushed flags, so the old mode
         flags_q <= irq_return_flags_i;
      end else if (wr_take && adr_i == page_select_pkg::FLAGS_OFFS) begin
         flags_q <= dat_i;
      end
   end

   // Copy of flags captured for the stack push on interrupt entry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pushed_flags_o <= page_select_pkg::FLAGS_RESET;
      end else if (irq_entry_i) begin
         pushed_flags_o <= flags_q;
      end
   end

   // Stack pointer, eight bits, wraps inside the page
   // The carry is dropped on purpose so the stack never leaves its page
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stack_ptr_q <= 8'h00;
      end else if (stack_push_i && !stack_pop_i) begin
         stack_ptr_q <= stack_ptr_q + 8'h01;
      end else if (stack_pop_i && !stack_push_i) begin
         stack_ptr_q <= stack_ptr_q - 8'h01;
      end
   end
   assign stack_ptr_o = stack_ptr_q;

   // Page selection per access class
   always_comb begin
      page_d = '0;
      case (acc_class_i)
         page_select_pkg::ACC_NORMAL: begin
            // Current pointer only when the upper mode bit is set
            if (mode[1]) begin
               page_d = cur_page_q[PAGE_W-1:0];
            end else begin
               page_d = '0;
            end
         end
         page_select_pkg::ACC_INDEXED: begin
            // Current pointer never consulted here
            case (mode)
               page_select_pkg::MODE_SINGLE: page_d = '0;
               page_select_pkg::MODE_SVC_STACK: page_d = stk_page_q[PAGE_W-1:0];
               page_select_pkg::MODE_INDEX: page_d = idx_page_q[PAGE_W-1:0];
               page_select_pkg::MODE_STACK_IDX: page_d = stk_page_q[PAGE_W-1:0];
               default: page_d = '0;
            endcase
         end
         page_select_pkg::ACC_STACK: begin
            // Live register value, so a new write applies at once
            page_d = stk_page_q[PAGE_W-1:0];
         end
         page_select_pkg::ACC_MOVE_READ: begin
            // Pointer byte in the current page, data via move pointer
            if (move_data_phase_i) begin
               page_d = move_rd_page_q[PAGE_W-1:0];
            end else if (mode[1]) begin
               page_d = cur_page_q[PAGE_W-1:0];
            end else begin
               page_d = '0;
            end
         end
         page_select_pkg::ACC_MOVE_WRITE: begin
            // Same pointer phases, data via the write pointer
            if (move_data_phase_i) begin
               page_d = move_wr_page_q[PAGE_W-1:0];
            end else if (mode[1]) begin
               page_d = cur_page_q[PAGE_W-1:0];
            end else begin
               page_d = '0;
            end
         end
         default: begin
            // Register-space indexed and unknown classes: no paging
            page_d = '0;
         end
      endcase
   end

   // Registered SRAM address, page above in-page byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         page_q <= '0;
         addr_q <= 8'h00;
         en_q <= 1'b0;
      end else begin
         page_q <= page_d;
         addr_q <= acc_addr_i;
         en_q <= acc_valid_i && (acc_class_i != page_select_pkg::ACC_REG_INDEXED);
      end
   end
   assign sram_addr_o = {page_q, addr_q};
   assign sram_page_o = page_q;
   assign sram_en_o = en_q;

   // Status: page that the last access used and current mode
   assign status_rd = {mode, 3'h0, 3'(page_q)};

   // Read data mux, registered with ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 8'h00;
      end else if (rd_take) begin
         case (adr_i)
            page_select_pkg::CUR_PAGE_OFFS: rdat_q <= cur_page_q;
            page_select_pkg::STK_PAGE_OFFS: rdat_q <= stk_page_q;
            page_select_pkg::IDX_PAGE_OFFS: rdat_q <= idx_page_q;
            page_select_pkg::MOVE_RD_OFFS: rdat_q <= move_rd_page_q;
            page_select_pkg::MOVE_WR_OFFS: rdat_q <= move_wr_page_q;
            page_select_pkg::FLAGS_OFFS: rdat_q <= flags_q;
            page_select_pkg::STATUS_OFFS: rdat_q <= status_rd;
            page_select_pkg::SCRATCH_OFFS: rdat_q <= scratch_q[0];
            page_select_pkg::SCRATCH_OFFS | 8'h01: rdat_q <= scratch_q[1];
            page_select_pkg::SCRATCH_OFFS | 8'h02: rdat_q <= scratch_q[2];
            page_select_pkg::SCRATCH_OFFS | 8'h03: rdat_q <= scratch_q[3];
            // Unmapped reads return zero
            default: rdat_q <= 8'h00;
         endcase
      end
   end
   assign dat_o = rdat_q;
   assign ack_o = ack_q;

   // Assertions: page chosen per mode and class, one cycle later
   AST_MODE0_NORMAL: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_class_i == 3'h0 && mode == 2'h0) |=> sram_page_o == '0)
      else $error("normal access not on page 0 in mode 00");
   AST_MODE1_IDX: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_class_i == 3'h1 && mode == 2'h1) |=> sram_page_o == $past(stk_page_q[PAGE_W-1:0]))
      else $error("mode 01 indexed page wrong");
   AST_MODE2_IDX: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_class_i == 3'h1 && mode == 2'h2) |=> sram_page_o == $past(idx_page_q[PAGE_W-1:0]))
      else $error("mode 10 indexed page wrong");
   AST_MODE3_IDX: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_class_i == 3'h1 && mode == 2'h3) |=> sram_page_o == $past(stk_page_q[PAGE_W-1:0]))
      else $error("mode 11 indexed page wrong");
   AST_CUR_NORMAL: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_class_i == 3'h0 && mode[1]) |=> sram_page_o == $past(cur_page_q[PAGE_W-1:0]))
      else $error("normal access ignores current pointer");
   AST_STACK_PAGE: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_class_i == 3'h2) |=> sram_page_o == $past(stk_page_q[PAGE_W-1:0]))
      else $error("stack access page wrong");

   // Move phases: pointer byte in the current page, data elsewhere
   AST_MOVE_RD_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_class_i == 3'h3 && move_data_phase_i)
      |=> sram_page_o == $past(move_rd_page_q[PAGE_W-1:0]))
      else $error("move read data page wrong");
   AST_MOVE_WR_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_class_i == 3'h4 && move_data_phase_i)
      |=> sram_page_o == $past(move_wr_page_q[PAGE_W-1:0]))
      else $error("move write data page wrong");
   AST_MOVE_PTR_PAGE0: assert property (@(posedge clk_i) disable iff (rst_i)
      ((acc_class_i == 3'h3 || acc_class_i == 3'h4) && !move_data_phase_i && !mode[1])
      |=> sram_page_o == '0)
      else $error("move pointer byte left page 0");

   // Register-space accesses never reach the SRAM
   AST_REG_IDX_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_class_i == 3'h5) |=> !sram_en_o)
      else $error("register-space access enabled the memory");
   AST_EN_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_valid_i && acc_class_i != 3'h5) |=> sram_en_o)
      else $error("memory access not enabled");
   AST_ADDR_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i |=> sram_addr_o[7:0] == $past(acc_addr_i))
      else $error("in-page address not carried");

   // Interrupt entry and return of the flags
   AST_IRQ_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_entry_i |=> (mode == 2'h0 && pushed_flags_o == $past(flags_q)))
      else $error("interrupt entry did not clear flags");
   AST_IRQ_RETURN: assert property (@(posedge clk_i) disable iff (rst_i)
      (irq_return_i && !irq_entry_i) |=> flags_q == $past(irq_return_flags_i))
      else $error("return did not restore flags");

   // Stack pointer wraps both ways inside its page
   AST_STACK_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
      (stack_push_i && !stack_pop_i && stack_ptr_q == 8'hff) |=> stack_ptr_q == 8'h00)
      else $error("stack pointer did not wrap");
   AST_STACK_WRAP_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
      (stack_pop_i && !stack_push_i && stack_ptr_q == 8'h00) |=> stack_ptr_q == 8'hff)
      else $error("stack pointer did not wrap downward");

   // Bus handshake: one answer per request, one cycle long
   AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   AST_ACK_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("request not acknowledged");

   // Main scenarios reached
   COV_MODE2: cover property (@(posedge clk_i) disable iff (rst_i)
      acc_class_i == 3'h1 && mode == 2'h2);
   COV_IRQ_RETURN: cover property (@(posedge clk_i) disable iff (rst_i)
      irq_entry_i ##[1:20] irq_return_i);
   COV_MOVE: cover property (@(posedge clk_i) disable iff (rst_i)
      acc_class_i == 3'h3 && move_data_phase_i);
   COV_WRAP: cover property (@(posedge clk_i) disable iff (rst_i)
      stack_pop_i && stack_ptr_q == 8'h00);

endmodule : sram_page_select

// [cpu_exec_model.sv]
// Execution unit model that issues accesses, stack steps and interrupt events
`timescale 1ns/100ps
module cpu_exec_model (
   input wire logic clk_i,
   output logic acc_valid_o,
   output logic [2:0] acc_class_o,
   output logic move_data_phase_o,
   output logic [7:0] acc_addr_o,
   output logic stack_push_o,
   output logic stack_pop_o,
   output logic irq_entry_o,
   output logic irq_return_o,
   output logic [7:0] irq_return_flags_o
);
   // Idle levels at time zero
   initial begin
      {acc_valid_o, acc_class_o, move_data_phase_o, acc_addr_o} = '0;
      {stack_push_o, stack_pop_o, irq_entry_o, irq_return_o, irq_return_flags_o} = '0;
   end
   // One access, held for one edge
   task automatic access(input logic [2:0] c, input logic ph, input logic [7:0] a);
      acc_valid_o <= 1'b1;
      acc_class_o <= c;
      move_data_phase_o <= ph;
      acc_addr_o <= a;
      @(posedge clk_i);
      acc_valid_o <= 1'b0;
   endtask : access
   // One stack pointer step or event pulse
   task automatic pulse(input logic [3:0] ev, input logic [7:0] f);
      {stack_push_o, stack_pop_o, irq_entry_o, irq_return_o} <= ev;
      irq_return_flags_o <= f; // Return brings back pushed flags only
      @(posedge clk_i);
      {stack_push_o, stack_pop_o, irq_entry_o, irq_return_o} <= 4'h0;
   endtask : pulse
endmodule : cpu_exec_model

// [tb_top.sv]
// Self-checking bench for the page selection block
`timescale 1ns/100ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, sel_i = 1'b0;
   logic [7:0] adr_i = 8'h00, dat_i = 8'h00, dat_o, rd, pushed_flags_o, stack_ptr_o;
   logic ack_o, acc_valid_i, move_data_phase_i, stack_push_i, stack_pop_i, irq_entry_i;
   logic irq_return_i;
   logic [2:0] acc_class_i, sram_page_o;
   logic [7:0] acc_addr_i, irq_return_flags_i;
   logic [10:0] sram_addr_o;
   logic sram_en_o;
   int err_count = 0, cmp_count = 0, cyc_cnt = 0;
   logic [2:0] idx_pg [4] = '{3'h0, 3'h2, 3'h3, 3'h2};
   logic [7:0] offs [6] = '{8'hd0, 8'hd1, 8'hd3, 8'hd4, 8'hd5, 8'hd8};
   always #5 clk_i = ~clk_i;
   sram_page_select u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
      .acc_valid_i(acc_valid_i), .acc_class_i(acc_class_i),
      .move_data_phase_i(move_data_phase_i), .acc_addr_i(acc_addr_i),
      .stack_push_i(stack_push_i), .stack_pop_i(stack_pop_i), .irq_entry_i(irq_entry_i),
      .irq_return_i(irq_return_i), .irq_return_flags_i(irq_return_flags_i),
      .sram_addr_o(sram_addr_o), .sram_en_o(sram_en_o), .sram_page_o(sram_page_o),
      .pushed_flags_o(pushed_flags_o), .stack_ptr_o(stack_ptr_o));
   cpu_exec_model u_cpu (.clk_i(clk_i), .acc_valid_o(acc_valid_i), .acc_class_o(acc_class_i),
      .move_data_phase_o(move_data_phase_i), .acc_addr_o(acc_addr_i),
      .stack_push_o(stack_push_i), .stack_pop_o(stack_pop_i), .irq_entry_o(irq_entry_i),
      .irq_return_o(irq_return_i), .irq_return_flags_o(irq_return_flags_i));
   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // Hang guard
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         err_count++;
         finish_test();
      end
   end
   // Compare and report
   task automatic check(input string n, input logic [10:0] e, input logic [10:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : check
   // Wishbone classic single cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 1'b1;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      {cyc_i, stb_i, we_i, sel_i} <= 4'h0;
      @(posedge clk_i);
   endtask : wb
   // Access then compare the page chosen
   task automatic acc(input logic [2:0] c, input logic ph, input logic [7:0] a,
         input logic [2:0] pg, input logic en);
      u_cpu.access(c, ph, a);
      @(posedge clk_i);
      check("sram_en", {10'h0, en}, {10'h0, sram_en_o});
      if (en) check("sram_addr", {pg, a}, sram_addr_o);
      if (en) check("sram_page", {8'h00, pg}, {8'h00, sram_page_o});
   endtask : acc
   // Reset values of pointers and flags, read and write of scratch and pointer registers
   task automatic regs_test();
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, offs[i], 8'h00);
         check("reset value", 11'h0, {3'h0, rd});
      end
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, 8'(8'h60 + i), 8'(8'ha5 + i));
         wb(1'b0, 8'(8'h60 + i), 8'h00);
         check("scratch", 11'(8'ha5 + i), {3'h0, rd});
      end
      wb(1'b0, 8'hd2, 8'h00);
      check("unmapped", 11'h0, {3'h0, rd});
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, offs[i], 8'(i + 1)); // Reserved bits written zero
         wb(1'b0, offs[i], 8'h00);
         check("pointer", 11'(i + 1), {3'h0, rd});
      end
   endtask : regs_test
   // Every page mode against every access class
   task automatic mode_test();
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, 8'hd8, 8'(m << 6));
         acc(3'h0, 1'b0, 8'h10, m[1] ? 3'h1 : 3'h0, 1'b1);
         acc(3'h1, 1'b0, 8'h20, idx_pg[m], 1'b1);
         acc(3'h2, 1'b0, 8'h30, 3'h2, 1'b1);
         acc(3'h3, 1'b0, 8'h40, m[1] ? 3'h1 : 3'h0, 1'b1);
         acc(3'h3, 1'b1, 8'h41, 3'h4, 1'b1);
         acc(3'h4, 1'b0, 8'h43, m[1] ? 3'h1 : 3'h0, 1'b1);
         acc(3'h4, 1'b1, 8'h42, 3'h5, 1'b1);
         acc(3'h5, 1'b0, 8'h50, 3'h0, 1'b0);
      end
      wb(1'b1, 8'hd1, 8'h06);
      acc(3'h2, 1'b0, 8'h31, 3'h6, 1'b1);
      wb(1'b0, 8'hd9, 8'h00);
      check("status", 11'h0c6, {3'h0, rd});
   endtask : mode_test
   // Interrupt entry and return, then stack pointer wrap
   task automatic irq_test();
      u_cpu.pulse(4'h2, 8'h00);
      @(posedge clk_i);
      check("pushed flags", 11'h0c0, {3'h0, pushed_flags_o});
      acc(3'h1, 1'b0, 8'h22, 3'h0, 1'b1);
      acc(3'h0, 1'b0, 8'h12, 3'h0, 1'b1);
      u_cpu.pulse(4'h1, 8'hc0);
      acc(3'h1, 1'b0, 8'h23, 3'h6, 1'b1);
      u_cpu.pulse(4'h4, 8'h00);
      @(posedge clk_i);
      check("sp wrap down", 11'h0ff, {3'h0, stack_ptr_o});
      u_cpu.pulse(4'h8, 8'h00);
      @(posedge clk_i);
      check("sp wrap up", 11'h000, {3'h0, stack_ptr_o});
   endtask : irq_test
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      regs_test();
      mode_test();
      irq_test();
      finish_test();
   end
endmodule : tb_top
